// ---- core/tsm_core.sv ----
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`include "tsm_params.svh"
module tsm_core
  import tsm_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger and pins
  input  wire logic        external_fire_input,
  input  wire logic        multipurpose_input,
  input  wire logic        laser_bridge,
  // sensor data
  input  wire logic        sample_valid,
  input  wire logic [31:0] head1_value,
  input  wire logic [31:0] head2_value,
  input  wire logic [31:0] encoder_value,
  // sensor side outputs
  output logic             head1_sync,
  output logic             head2_sync,
  output logic             head1_laser,
  output logic             head2_laser,
  output logic             fire_threshold_high,
  output logic             encoder_latch,
  // result stream
  output logic             result_valid,
  output logic [31:0]      combined_result
);
  // configuration
  tsm_trig_type  trig_mode;
  logic          trig_polarity_cmd;   // 1 = rising edge
  logic          trig_threshold;      // 1 = high_threshold_logic
  logic [13:0]   burst_length_cmd;
  tsm_sync_type  sync_mode;
  logic          sync_threshold;
  logic [1:0]    channel_kind_setting; // bit n set = channel n+1 encoder
  logic          sync_channel;
  tsm_comb_type  combine_mode_cmd;
  logic [19:0]   sample_rate_cmd;
  logic          master_on;
  logic [31:0]   master_value;
  logic [31:0]   master_offset;
  logic          point1_set;
  logic          point2_set;
  logic [31:0]   point1;
  logic [31:0]   point2;
  logic [31:0]   range1;
  logic [31:0]   range2;
  logic [15:0]   corr_gain;
  logic [1:0]    emitter_switch_cmd;
  logic          mfi_clears_stats;
  logic [7:0]    err_code;
  // datapath state
  tsm_burst_type burst_state;
  logic [13:0]   burst_left;
  logic          fire_prev;
  logic          mfi_prev;
  logic [31:0]   stat_min;
  logic [31:0]   stat_max;
  logic          stat_any;

  // apb decode
  wire access     = psel && penable;
  wire wr         = access && pwrite;
  wire hit_trig   = (paddr == `TSM_OFF_TRIG);
  wire hit_count  = (paddr == `TSM_OFF_COUNT);
  wire hit_cmd    = (paddr == `TSM_OFF_CMD);
  wire hit_sync   = (paddr == `TSM_OFF_SYNC);
  wire hit_comb   = (paddr == `TSM_OFF_COMBINE);
  wire hit_rate   = (paddr == `TSM_OFF_RATE);
  wire hit_master = (paddr == `TSM_OFF_MASTER);
  wire hit_sc1    = (paddr == `TSM_OFF_SCALE1);
  wire hit_sc2    = (paddr == `TSM_OFF_SCALE2);
  wire hit_r1     = (paddr == `TSM_OFF_RANGE1);
  wire hit_r2     = (paddr == `TSM_OFF_RANGE2);
  wire hit_gain   = (paddr == `TSM_OFF_GAIN);
  wire hit_stat   = (paddr == `TSM_OFF_STATUS);
  wire hit_res    = (paddr == `TSM_OFF_RESULT);
  wire hit_min    = (paddr == `TSM_OFF_MIN);
  wire hit_max    = (paddr == `TSM_OFF_MAX);
  wire hit_peak   = (paddr == `TSM_OFF_PEAK);
  wire hit_laser  = (paddr == `TSM_OFF_LASER);
  wire mapped     = hit_trig | hit_count | hit_cmd | hit_sync | hit_comb
                  | hit_rate | hit_master | hit_sc1 | hit_sc2 | hit_r1
                  | hit_r2 | hit_gain | hit_stat | hit_res | hit_min
                  | hit_max | hit_peak | hit_laser;

  function automatic logic signed_in_limit(input logic [31:0] v);
    signed_in_limit = ($signed(v) <= `TSM_MASTER_LIM) &&
                      ($signed(v) >= -`TSM_MASTER_LIM);
  endfunction : signed_in_limit

  wire rate_ok = (sync_mode != TSM_SYNC_NONE) ||
                 ((pwdata[19:0] >= `TSM_RATE_MIN) &&
                  (pwdata[19:0] <= `TSM_RATE_MAX));
  wire soft_cmd  = wr && hit_cmd && pwdata[`TSM_CMD_SOFT_FIRE];
  wire soft_ok   = soft_cmd && (trig_mode == TSM_TRIG_SOFT);
  wire soft_bad  = soft_cmd && (trig_mode != TSM_TRIG_SOFT);
  // master value arrives as a 31-bit signed field
  wire [31:0] new_master = {pwdata[30], pwdata[30:0]};
  wire bad_write = wr && ((hit_rate && !rate_ok) ||
                   (hit_master && pwdata[31] == 1'b0 &&
                    !signed_in_limit(new_master)) || soft_bad);

  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || bad_write);

  // trigger sources
  wire fire_edge = trig_polarity_cmd ? (external_fire_input && !fire_prev)
                 : (!external_fire_input && fire_prev);
  wire fire_level = (external_fire_input == trig_polarity_cmd);
  wire enc_ch     = channel_kind_setting[sync_channel];
  wire event_fire = ((trig_mode == TSM_TRIG_EDGE) && fire_edge) ||
                    soft_ok;

  // pacing
  logic tick;
  tsm_pacer u_pacer (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (sample_rate_cmd),
    .tick    (tick)
  );
  wire ch_tick = enc_ch ? tick : sample_valid;
  wire pace    = (sync_mode == TSM_SYNC_NONE)     ? tick
               : (sync_mode == TSM_SYNC_EXTERNAL) ? fire_edge
               : (sync_mode == TSM_SYNC_CHANNEL)  ? ch_tick
               : tick;
  assign head1_sync = (sync_mode == TSM_SYNC_INTERNAL) ? tick
                    : (sync_mode == TSM_SYNC_EXTERNAL)
                      ? external_fire_input : 1'b0;
  assign head2_sync = head1_sync;
  assign fire_threshold_high = (sync_mode == TSM_SYNC_EXTERNAL)
                             ? sync_threshold : trig_threshold;
  assign encoder_latch = (sync_mode == TSM_SYNC_CHANNEL) && !enc_ch
                       && sample_valid;
  assign head1_laser = laser_bridge ? emitter_switch_cmd[0] : 1'b1;
  assign head2_laser = laser_bridge ? emitter_switch_cmd[1] : 1'b1;

  // combining
  logic [31:0] raw;
  logic [31:0] next_combined;
  logic        needs_enc_err;
  always_comb
  begin
    needs_enc_err = 1'b0;
    case (combine_mode_cmd)
      TSM_COMB_FIRST:
      begin
        raw = head1_value;
        needs_enc_err = channel_kind_setting[0];
      end
      TSM_COMB_SECOND:
      begin
        raw = head2_value;
        needs_enc_err = channel_kind_setting[1];
      end
      TSM_COMB_THICK:
      begin
        raw = master_on
            ? master_offset - head1_value - head2_value
            : (range1 - head1_value) + (range2 - head2_value);
        needs_enc_err = |channel_kind_setting;
      end
      default:
      begin
        raw = head1_value - head2_value;
        needs_enc_err = |channel_kind_setting;
      end
    endcase
  end
  // master shift applies in all modes except thickness, which folds it in
  wire [31:0] mastered = (master_on && combine_mode_cmd != TSM_COMB_THICK)
                       ? raw - master_offset + master_value : raw;
  // offset chosen so the value at capture reads back as the master value
  wire [31:0] next_offset = (combine_mode_cmd == TSM_COMB_THICK)
                          ? new_master + head1_value + head2_value
                          : raw;
  wire [47:0] scaled   = $signed(mastered) * $signed({1'b0, corr_gain});
  wire corr_on = point1_set && point2_set;
  // offset derived from first point; slope from gain register
  assign next_combined = corr_on ? (scaled[43:12] + point1) : mastered;

  wire emit = (burst_state != TSM_BURST_IDLE ||
              ((trig_mode == TSM_TRIG_GATE) && fire_level) ||
              (trig_mode == TSM_TRIG_NONE)) && pace;
  wire clr_stats = (wr && hit_cmd && pwdata[`TSM_CMD_CLR_STAT]) ||
                   (mfi_clears_stats && multipurpose_input && !mfi_prev);
  wire take = emit && !needs_enc_err;

  // burst control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      burst_state <= TSM_BURST_IDLE;
      burst_left  <= 14'h0000;
    end
    else
    begin
      case (burst_state)
        TSM_BURST_IDLE:
          if (event_fire && burst_length_cmd == `TSM_COUNT_INFINITE)
            burst_state <= TSM_BURST_CONT;
          else if (event_fire && burst_length_cmd != 14'h0000)
          begin
            burst_state <= TSM_BURST_COUNT;
            burst_left  <= burst_length_cmd;
          end
        TSM_BURST_COUNT:
          if (event_fire && burst_length_cmd == 14'h0000)
          begin
            burst_state <= TSM_BURST_IDLE;
            burst_left  <= 14'h0000;
          end
          else if (event_fire && burst_length_cmd == `TSM_COUNT_INFINITE)
            burst_state <= TSM_BURST_CONT;
          else if (event_fire)
            burst_left <= burst_length_cmd;
          else if (emit && burst_left == 14'h0001)
          begin
            burst_state <= TSM_BURST_IDLE;
            burst_left  <= 14'h0000;
          end
          else if (emit)
            burst_left <= burst_left - 14'h0001;
        TSM_BURST_CONT:
          if (soft_ok || (event_fire && burst_length_cmd == 14'h0000))
            burst_state <= TSM_BURST_IDLE;
        default:
          burst_state <= TSM_BURST_IDLE;
      endcase
    end
  end

  // result, statistics, input edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_valid    <= 1'b0;
      combined_result <= 32'h00000000;
      stat_min        <= 32'h00000000;
      stat_max        <= 32'h00000000;
      stat_any        <= 1'b0;
      fire_prev       <= 1'b0;
      mfi_prev        <= 1'b0;
    end
    else
    begin
      fire_prev    <= external_fire_input;
      mfi_prev     <= multipurpose_input;
      result_valid <= take;
      if (take)
        combined_result <= next_combined;
      // a value arriving with the clear starts the new statistics
      if (take)
      begin
        stat_any <= 1'b1;
        if (clr_stats || !stat_any ||
            $signed(next_combined) < $signed(stat_min))
          stat_min <= next_combined;
        if (clr_stats || !stat_any ||
            $signed(next_combined) > $signed(stat_max))
          stat_max <= next_combined;
      end
      else if (clr_stats)
      begin
        stat_any <= 1'b0;
        stat_min <= 32'h00000000;
        stat_max <= 32'h00000000;
      end
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_mode            <= TSM_TRIG_NONE;
      trig_polarity_cmd    <= 1'b1;
      trig_threshold       <= 1'b0;
      burst_length_cmd     <= `TSM_COUNT_RESET;
      sync_mode            <= TSM_SYNC_INTERNAL;
      sync_threshold       <= 1'b0;
      sync_channel         <= 1'b0;
      channel_kind_setting <= 2'b00;
      combine_mode_cmd     <= TSM_COMB_FIRST;
      sample_rate_cmd      <= `TSM_RATE_RESET;
      master_on            <= 1'b0;
      master_value         <= 32'h00000000;
      master_offset        <= 32'h00000000;
      point1_set           <= 1'b0;
      point2_set           <= 1'b0;
      point1               <= 32'h00000000;
      point2               <= 32'h00000000;
      range1               <= 32'h00000000;
      range2               <= 32'h00000000;
      corr_gain            <= 16'h1000;
      emitter_switch_cmd   <= 2'b11;
      mfi_clears_stats     <= 1'b0;
      err_code             <= 8'h00;
    end
    else
    begin
      if (wr && hit_trig)
      begin
        trig_mode         <= tsm_trig_type'(pwdata[1:0]);
        trig_polarity_cmd <= pwdata[4];
        trig_threshold    <= pwdata[5];
      end
      if (wr && hit_count)
        burst_length_cmd <= pwdata[13:0];
      if (wr && hit_sync)
      begin
        sync_mode            <= tsm_sync_type'(pwdata[1:0]);
        sync_threshold       <= pwdata[4];
        sync_channel         <= pwdata[8];
        channel_kind_setting <= pwdata[13:12];
      end
      if (wr && hit_comb)
        combine_mode_cmd <= tsm_comb_type'(pwdata[1:0]);
      if (wr && hit_rate && rate_ok)
        sample_rate_cmd <= pwdata[19:0];
      if (wr && hit_master && !pwdata[31] &&
          signed_in_limit(new_master))
      begin
        master_on     <= 1'b1;
        master_value  <= new_master;
        master_offset <= next_offset;
      end
      else if (wr && hit_master && pwdata[31])
        master_on <= 1'b0;
      if (wr && hit_sc1)
      begin
        point1_set <= !pwdata[31];
        point1     <= {pwdata[30], pwdata[30:0]};
      end
      if (wr && hit_sc2)
      begin
        point2_set <= !pwdata[31];
        point2     <= {pwdata[30], pwdata[30:0]};
      end
      if (wr && hit_r1)
        range1 <= pwdata;
      if (wr && hit_r2)
        range2 <= pwdata;
      if (wr && hit_gain)
        corr_gain <= pwdata[15:0];
      if (wr && hit_laser)
      begin
        emitter_switch_cmd <= pwdata[1:0];
        mfi_clears_stats   <= pwdata[4];
      end
      // new error wins over software clear in the same cycle
      if (soft_bad)
        err_code <= `TSM_ERR_SOFT_OFF;
      else if (emit && needs_enc_err)
        err_code <= `TSM_ERR_ENCODER;
      else if (wr && hit_cmd && pwdata[`TSM_CMD_CLR_ERR])
        err_code <= 8'h00;
    end
  end

  // read mux
  assign prdata =
      hit_trig   ? {26'h0, trig_threshold, trig_polarity_cmd, 2'b00,
                    trig_mode} :
      hit_count  ? {18'h0, burst_length_cmd} :
      hit_sync   ? {18'h0, channel_kind_setting, 3'b000, sync_channel,
                    3'b000, sync_threshold, 2'b00, sync_mode} :
      hit_comb   ? {30'h0, combine_mode_cmd} :
      hit_rate   ? {12'h000, sample_rate_cmd} :
      hit_master ? master_value :
      hit_sc1    ? point1 :
      hit_sc2    ? point2 :
      hit_r1     ? range1 :
      hit_r2     ? range2 :
      hit_gain   ? {16'h0000, corr_gain} :
      hit_stat   ? {err_code, 6'h00, burst_left, master_on, corr_on,
                    burst_state} :
      hit_res    ? combined_result :
      hit_min    ? stat_min :
      hit_max    ? stat_max :
      hit_peak   ? (stat_max - stat_min) :
      hit_laser  ? {27'h0, mfi_clears_stats, 2'b00, emitter_switch_cmd} :
      32'h00000000;

  // assertions
  a_soft_refused: assert property (@(posedge pclk) disable iff (!presetn)
    soft_bad |=> err_code == `TSM_ERR_SOFT_OFF)
    else $error("soft fire outside software mode not flagged");
  a_burst_load: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_state == TSM_BURST_IDLE && event_fire &&
     burst_length_cmd != 14'h0000 &&
     burst_length_cmd != `TSM_COUNT_INFINITE)
    |=> burst_state == TSM_BURST_COUNT &&
        burst_left == $past(burst_length_cmd))
    else $error("burst counter not loaded");
  a_cont_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_state == TSM_BURST_CONT && soft_ok)
    |=> burst_state == TSM_BURST_IDLE)
    else $error("continuous output not ended");
  a_inf_start: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_state == TSM_BURST_IDLE && event_fire &&
     burst_length_cmd == `TSM_COUNT_INFINITE)
    |=> burst_state == TSM_BURST_CONT)
    else $error("infinite count did not start output");
  a_enc_block: assert property (@(posedge pclk) disable iff (!presetn)
    (emit && needs_enc_err) |=> !result_valid)
    else $error("value emitted from encoder channel");
  a_corr_off: assert property (@(posedge pclk) disable iff (!presetn)
    (emit && !needs_enc_err && !corr_on)
    |=> combined_result == $past(mastered))
    else $error("correction applied with a point cleared");
  a_int_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode == TSM_SYNC_INTERNAL) |-> head1_sync == tick &&
                                          head2_sync == tick)
    else $error("internal sync not driven");
  a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_stats && !take) |=> !stat_any && stat_max == stat_min)
    else $error("statistics not cleared");
  sequence s_zero_fire;
    burst_state != TSM_BURST_IDLE && event_fire &&
    burst_length_cmd == 14'h0000;
  endsequence
  sequence s_burst_idle;
    burst_state == TSM_BURST_IDLE;
  endsequence
  a_zero_stop: assert property (@(posedge pclk) disable iff (!presetn)
    s_zero_fire |=> s_burst_idle)
    else $error("zero count did not stop output");
endmodule : tsm_core

// ---- shared/tsm_params.svh ----
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH
// register byte offsets
`define TSM_OFF_TRIG      12'h000
`define TSM_OFF_COUNT     12'h004
`define TSM_OFF_CMD       12'h008
`define TSM_OFF_SYNC      12'h00C
`define TSM_OFF_COMBINE   12'h010
`define TSM_OFF_RATE      12'h014
`define TSM_OFF_MASTER    12'h018
`define TSM_OFF_SCALE1    12'h01C
`define TSM_OFF_SCALE2    12'h020
`define TSM_OFF_RANGE1    12'h024
`define TSM_OFF_RANGE2    12'h028
`define TSM_OFF_GAIN      12'h02C
`define TSM_OFF_STATUS    12'h030
`define TSM_OFF_RESULT    12'h034
`define TSM_OFF_MIN       12'h038
`define TSM_OFF_MAX       12'h03C
`define TSM_OFF_PEAK      12'h040
`define TSM_OFF_LASER     12'h044
// command register bits
`define TSM_CMD_SOFT_FIRE 0
`define TSM_CMD_CLR_STAT  1
`define TSM_CMD_MASTER    2
`define TSM_CMD_CLR_ERR   3
// counts
`define TSM_COUNT_INFINITE 14'h3FFF
`define TSM_COUNT_RESET    14'h0001
// rate in Hz units of kHz*1000: 0.100 .. 100.000
`define TSM_RATE_MIN       20'h00064
`define TSM_RATE_MAX       20'h186A0
`define TSM_RATE_RESET     20'h003E8
`define TSM_CLK_KHZ        40000
// master limit in 1/10000 mm units: 1024.0 mm
`define TSM_MASTER_LIM     32'sd10240000
// error codes
`define TSM_ERR_SOFT_OFF   8'h43
`define TSM_ERR_ENCODER    8'h80
`endif

// ---- shared/tsm_pkg.sv ----
package tsm_pkg;
  typedef enum logic [1:0] {
    TSM_TRIG_NONE = 2'b00,
    TSM_TRIG_EDGE = 2'b01,
    TSM_TRIG_GATE = 2'b10,
    TSM_TRIG_SOFT = 2'b11
  } tsm_trig_type;
  typedef enum logic [1:0] {
    TSM_SYNC_NONE     = 2'b00,
    TSM_SYNC_INTERNAL = 2'b01,
    TSM_SYNC_EXTERNAL = 2'b10,
    TSM_SYNC_CHANNEL  = 2'b11
  } tsm_sync_type;
  typedef enum logic [1:0] {
    TSM_COMB_FIRST  = 2'b00,
    TSM_COMB_SECOND = 2'b01,
    TSM_COMB_THICK  = 2'b10,
    TSM_COMB_DIFF   = 2'b11
  } tsm_comb_type;
  typedef enum logic [1:0] {
    TSM_BURST_IDLE  = 2'b00,
    TSM_BURST_COUNT = 2'b01,
    TSM_BURST_CONT  = 2'b10
  } tsm_burst_type;
endpackage : tsm_pkg

// ---- core/tsm_pacer.sv ----
`timescale 1ns/10ps
`include "tsm_params.svh"
// divides pclk into a sample tick at the requested rate
module tsm_pacer
  import tsm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic [19:0] rate,
  // tick
  output logic             tick
);
  logic [31:0] acc;
  logic [32:0] sum;
  localparam logic [32:0] WRAP = 33'(`TSM_CLK_KHZ * 1000);

  // phase accumulator keeps fractional rates exact over time
  assign sum  = {1'b0, acc} + {13'h0000, rate};
  assign tick = (sum >= WRAP);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 32'h00000000;
    else if (tick)
      acc <= 32'(sum - WRAP);
    else
      acc <= sum[31:0];
  end
endmodule : tsm_pacer

// ---- tb/tsm_heads.sv ----
`timescale 1ns/10ps
module tsm_heads
  import tsm_pkg::*;
#(
  parameter logic [31:0] H1 = 32'h00000500,
  parameter logic [31:0] H2 = 32'h00000200
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pacing from the block
  input  wire logic        head1_sync,
  // sample stream
  output logic             sample_valid,
  output logic [31:0]      head1_value,
  output logic [31:0]      head2_value,
  output logic [31:0]      encoder_value
);
  logic [5:0] free_cnt;
  // answers a sync pulse, free-runs when not paced
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      free_cnt     <= 6'h00;
      sample_valid <= 1'b0;
    end
    else
    begin
      free_cnt     <= free_cnt + 6'h01;
      sample_valid <= head1_sync | (free_cnt == 6'h3F);
    end
  assign head1_value   = H1;
  assign head2_value   = H2;
  assign encoder_value = {26'h0000000, free_cnt};
endmodule : tsm_heads

// ---- tb/trigger_sync_measure_control_bench.sv ----
`timescale 1ns/10ps
`include "tsm_params.svh"
module trigger_sync_measure_control_bench;
  import tsm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, laser_bridge;
  logic        pready, pslverr, sample_valid, result_valid, er;
  logic        head1_sync, head1_laser, head2_laser, head2_sync;
  logic        fire, mfi, thr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, head1_value, head2_value, rd;
  logic [31:0] encoder_value, combined_result;
  int          n_errors, checks, n_pulse, n0;
  tsm_core u_tsm_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_fire_input(fire), .multipurpose_input(mfi),
    .laser_bridge(laser_bridge), .sample_valid(sample_valid),
    .head1_value(head1_value), .head2_value(head2_value),
    .encoder_value(encoder_value), .head1_sync(head1_sync),
    .head2_sync(head2_sync), .head1_laser(head1_laser),
    .head2_laser(head2_laser), .fire_threshold_high(thr), .encoder_latch(),
    .result_valid(result_valid), .combined_result(combined_result));
  tsm_heads u_tsm_heads (.pclk(pclk), .presetn(presetn),
    .head1_sync(head1_sync), .sample_valid(sample_valid),
    .head1_value(head1_value), .head2_value(head2_value),
    .encoder_value(encoder_value));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (result_valid === 1'b1)
      n_pulse++;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until pready is seen high with penable
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_reset();
    apb(1'b0, `TSM_OFF_COUNT, 32'h0);
    chk("count", rd, 32'h00000001);
    apb(1'b0, `TSM_OFF_SYNC, 32'h0);
    chk("sync", {30'h0, rd[1:0]}, 32'h00000001);
    apb(1'b0, `TSM_OFF_TRIG, 32'h0);
    chk("trig", {26'h0, rd[5:0]}, 32'h00000010);
    chk("lasers", {30'h0, head1_laser, head2_laser}, 32'h3);
    $display("done reset");
  endtask : t_reset
  task automatic t_refuse();
    apb(1'b1, `TSM_OFF_CMD, 32'h00000001);
    chk("soft_err", {31'h0, er}, 32'h1);
    apb(1'b0, `TSM_OFF_STATUS, 32'h0);
    chk("err_code", {24'h0, rd[31:24]}, 32'h00000043);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, `TSM_OFF_SYNC, 32'h0);
    apb(1'b1, `TSM_OFF_RATE, 32'h00000063);
    chk("rate_low", {31'h0, er}, 32'h1);
    apb(1'b1, `TSM_OFF_RATE, 32'h000186A0);
    chk("rate_max", {31'h0, er}, 32'h0);
    $display("done refuse");
  endtask : t_refuse
  task automatic t_burst();
    apb(1'b1, `TSM_OFF_COMBINE, 32'h00000003);
    apb(1'b1, `TSM_OFF_TRIG, 32'h00000013);
    apb(1'b1, `TSM_OFF_COUNT, 32'h00000003);
    repeat (900) @(posedge pclk);
    n0 = n_pulse;
    apb(1'b1, `TSM_OFF_CMD, 32'h00000001);
    chk("fire_ok", {31'h0, er}, 32'h0);
    repeat (3000) @(posedge pclk);
    chk("burst", n_pulse - n0, 32'h3);
    chk("diff", combined_result, 32'h00000300);
    $display("done burst");
  endtask : t_burst
  task automatic t_endless();
    apb(1'b1, `TSM_OFF_COUNT, 32'h00003FFF);
    apb(1'b1, `TSM_OFF_CMD, 32'h00000001);
    repeat (500) @(posedge pclk);
    n0 = n_pulse;
    repeat (2000) @(posedge pclk);
    chk("endless", {31'h0, n_pulse - n0 > 3}, 32'h1);
    apb(1'b1, `TSM_OFF_CMD, 32'h00000001);
    repeat (10) @(posedge pclk);
    n0 = n_pulse;
    repeat (2000) @(posedge pclk);
    chk("stopped", n_pulse - n0, 32'h0);
    $display("done endless");
  endtask : t_endless
  task automatic t_laser();
    laser_bridge <= 1'b1;
    apb(1'b1, `TSM_OFF_LASER, 32'h00000001);
    chk("laser", {30'h0, head1_laser, head2_laser}, 32'h2);
    $display("done laser");
  endtask : t_laser
  task automatic t_trig();
    apb(1'b1, `TSM_OFF_COUNT, 32'h2);
    apb(1'b1, `TSM_OFF_TRIG, 32'h11);
    n0 = n_pulse;
    fire <= 1'b1;
    repeat (2000) @(posedge pclk);
    chk("rise", n_pulse - n0, 32'h2);
    apb(1'b1, `TSM_OFF_TRIG, 32'h01);
    n0 = n_pulse;
    fire <= 1'b0;
    repeat (2000) @(posedge pclk);
    chk("fall", n_pulse - n0, 32'h2);
    apb(1'b1, `TSM_OFF_TRIG, 32'h12);
    n0 = n_pulse;
    fire <= 1'b1;
    repeat (2000) @(posedge pclk);
    chk("gate", {31'h0, n_pulse - n0 > 3}, 32'h1);
    fire <= 1'b0;
    repeat (10) @(posedge pclk);
    n0 = n_pulse;
    repeat (2000) @(posedge pclk);
    chk("gate_off", n_pulse - n0, 32'h0);
    apb(1'b1, `TSM_OFF_COUNT, 32'h3FFF);
    apb(1'b1, `TSM_OFF_TRIG, 32'h11);
    n0 = n_pulse;
    fire <= 1'b1;
    repeat (900) @(posedge pclk);
    chk("cont", {31'h0, n_pulse != n0}, 32'h1);
    apb(1'b1, `TSM_OFF_COUNT, 32'h0);
    fire <= 1'b0;
    @(posedge pclk);
    fire <= 1'b1;
    repeat (10) @(posedge pclk);
    n0 = n_pulse;
    repeat (2000) @(posedge pclk);
    chk("zero_stop", n_pulse - n0, 32'h0);
    apb(1'b1, `TSM_OFF_SYNC, 32'h12);
    chk("ext_sync", {29'h0, head1_sync, head2_sync, thr}, 32'h7);
    apb(1'b1, `TSM_OFF_SYNC, 32'h0);
    $display("done trig");
  endtask : t_trig
  task automatic t_stats();
    apb(1'b1, `TSM_OFF_TRIG, 32'h10);
    apb(1'b1, `TSM_OFF_COMBINE, 32'h0);
    repeat (1000) @(posedge pclk);
    apb(1'b1, `TSM_OFF_COMBINE, 32'h3);
    repeat (1000) @(posedge pclk);
    apb(1'b1, `TSM_OFF_TRIG, 32'h13);
    apb(1'b0, `TSM_OFF_PEAK, 32'h0);
    chk("peak", rd, 32'h200);
    apb(1'b1, `TSM_OFF_CMD, 32'h2);
    apb(1'b0, `TSM_OFF_MAX, 32'h0);
    chk("max_clr", rd, 32'h0);
    apb(1'b1, `TSM_OFF_TRIG, 32'h10);
    repeat (1000) @(posedge pclk);
    apb(1'b1, `TSM_OFF_TRIG, 32'h13);
    apb(1'b1, `TSM_OFF_LASER, 32'h13);
    mfi <= 1'b1;
    apb(1'b0, `TSM_OFF_MIN, 32'h0);
    chk("mfi_clr", rd, 32'h0);
    mfi <= 1'b0;
    $display("done stats");
  endtask : t_stats
  task automatic t_enc();
    apb(1'b1, `TSM_OFF_SYNC, 32'h1000);
    apb(1'b1, `TSM_OFF_TRIG, 32'h10);
    n0 = n_pulse;
    repeat (1000) @(posedge pclk);
    chk("enc_hold", n_pulse - n0, 32'h0);
    apb(1'b0, `TSM_OFF_STATUS, 32'h0);
    chk("enc_err", {24'h0, rd[31:24]}, 32'h80);
    apb(1'b1, `TSM_OFF_SYNC, 32'h0);
    $display("done enc");
  endtask : t_enc
  task automatic t_master();
    apb(1'b1, `TSM_OFF_MASTER, 32'h100);
    repeat (1000) @(posedge pclk);
    chk("master", combined_result, 32'h100);
    apb(1'b1, `TSM_OFF_MASTER, 32'h7FFFFF00);
    repeat (1000) @(posedge pclk);
    chk("master_neg", combined_result, 32'hFFFFFF00);
    apb(1'b1, `TSM_OFF_MASTER, 32'h00A00000);
    chk("master_lim", {31'h0, er}, 32'h1);
    apb(1'b1, `TSM_OFF_MASTER, 32'h80000000);
    apb(1'b1, `TSM_OFF_RANGE1, 32'h1000);
    apb(1'b1, `TSM_OFF_RANGE2, 32'h1000);
    apb(1'b1, `TSM_OFF_COMBINE, 32'h2);
    repeat (1000) @(posedge pclk);
    chk("thick", combined_result, 32'h1900);
    apb(1'b1, `TSM_OFF_MASTER, 32'h100);
    apb(1'b1, `TSM_OFF_SCALE1, 32'h10);
    apb(1'b1, `TSM_OFF_SCALE2, 32'h20);
    repeat (1000) @(posedge pclk);
    chk("corr", combined_result, 32'h110);
    apb(1'b1, `TSM_OFF_SCALE2, 32'h80000000);
    repeat (1000) @(posedge pclk);
    chk("corr_off", combined_result, 32'h100);
    $display("done master");
  endtask : t_master
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    laser_bridge = 1'b0;
    fire         = 1'b0;
    mfi          = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_refuse();
    t_burst();
    t_endless();
    t_trig();
    t_stats();
    t_enc();
    t_master();
    t_laser();
    give_verdict();
  end
  // all scenarios together need about 30000 cycles
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
endmodule : trigger_sync_measure_control_bench
